//--- design/csi_lane_map.svh
// Timing figures, codes and reset values for the lane sequencer
`ifndef CSI_LANE_MAP_SVH
`define CSI_LANE_MAP_SVH

`define CORE_PERIOD_PS     25000
`define NUM_LANES          4
`define UI_MIN_PS          1131
`define UI_150_PS          6667
`define UI_300_PS          3334
`define UI_450_PS          2223
`define UI_600_PS          1667
`define T_LPX_MIN_PS       50000
`define T_CLK_PRE_MIN_PS   8000
`define T_CLK_PREP_MIN_PS  38000
`define T_CLK_PREP_MAX_PS  95000
`define T_CLK_PZ_MIN_PS    300000
`define T_HS_PREP_MIN_PS   40000
`define HS_PREP_MIN_UI     4
`define T_HS_PREP_MAX_PS   85000
`define HS_PREP_MAX_UI     6
`define T_HS_PZ_MIN_PS     145000
`define HS_PZ_MIN_UI       10
`define TRAIL_MIN_UI       8
`define T_TRAIL_MIN_PS     60000
`define TRAIL_ADD_UI       4
`define T_EOT_MAX_PS       105000
`define EOT_MAX_UI         12
`define T_EXIT_MIN_PS      100000
`define SYNC_BYTE          8'hb8
`define CLK_BYTE           8'haa
`define LINE_RESET         44'hff0_0000_0000

`endif

//--- design/csi_lane_pkg.sv
// Types shared by the lane sequencer, the receiver model and the bench
package csi_lane_pkg;
  typedef struct packed {
    logic [3:0] clk_role;  // 1 = lane carries the clock
    logic [3:0] inv_p;     // Invert P wire
    logic [3:0] inv_n;     // Invert N wire
    logic [1:0] rate;      // 0:150 1:300 2:450 3:600 Mbps
  } lane_cfg_t;

  typedef struct packed {
    logic        last;
    logic [31:0] data;     // One byte per lane, lane 0 in bits 7:0
  } beat_t;

  typedef struct packed {
    logic [3:0]  lp_p;
    logic [3:0]  lp_n;
    logic [3:0]  hs_en;
    logic [31:0] hs_byte;
  } line_t;

  typedef enum logic [4:0] {
    C_OFF  = 5'b00001,
    C_LP01 = 5'b00010,
    C_LP00 = 5'b00100,
    C_HS0  = 5'b01000,
    C_RUN  = 5'b10000
  } clk_st_t;

  typedef enum logic [6:0] {
    D_LP11  = 7'b0000001,
    D_LP01  = 7'b0000010,
    D_LP00  = 7'b0000100,
    D_HS0   = 7'b0001000,
    D_SYNC  = 7'b0010000,
    D_PAY   = 7'b0100000,
    D_TRAIL = 7'b1000000
  } dat_st_t;
endpackage

//--- design/csi_beat_buf.sv
// Small valid/ready buffer holding payload beats ahead of the sequencer
`timescale 1ns/100ps
module csi_beat_buf #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             push, pop;

  // Pointer step with wrap at the depth
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Honest full and empty flags
  assign in_ready  = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  // Next pointers and fill level
  always_comb begin
    wp_nxt  = push ? step(wp_r) : wp_r;
    rp_nxt  = pop ? step(rp_r) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = CW'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = CW'(cnt_r - 1'b1);
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule // csi_beat_buf

//--- design/csi_dphy_lane_sequencer.sv
// Lane sequencer: clock and data lane line states, link-side pin stage
`timescale 1ns/100ps
`include "csi_lane_map.svh"
module csi_dphy_lane_sequencer (
  input  wire logic                    CORE_CLK,
  input  wire logic                    SRST,
  input  wire logic                    CE,
  input  wire logic                    IF_EN,
  input  wire csi_lane_pkg::lane_cfg_t CFG,
  input  wire logic                    DIN_VALID,
  output logic                         DIN_READY,
  input  wire csi_lane_pkg::beat_t     DIN,
  input  wire logic                    LINK_CLK,
  output csi_lane_pkg::line_t          LANE_OUT,
  output logic                         CLK_LANE_HS,
  output logic                         BURST_BUSY
);
  import csi_lane_pkg::*;

  clk_st_t    c_state_r, c_state_nxt;
  dat_st_t    d_state_r, d_state_nxt;
  logic [5:0] c_cnt_r, c_cnt_nxt, d_cnt_r, d_cnt_nxt;
  logic       c_sent_r, c_sent_nxt, d_sent_r, d_sent_nxt;
  logic [31:0] last_r, last_nxt;
  logic [5:0] t_lpx, t_clk_pre, t_clk_prep, t_clk_zero;
  logic [5:0] t_hs_prep, t_hs_zero, t_trail, t_exit;
  int         ui;
  beat_t      head;
  logic       head_valid, pop, load, hs_free, pre_ok;
  line_t      word_r, word_nxt;
  logic       req_r, req_nxt, ack_s1, ack_s2;
  logic       rq_s1, rq_s2, ack_r, ack_nxt, lrst_s1, lrst_s2;
  line_t      out_r, out_nxt;

  // Least time to core cycles, rounded up, never below one
  function automatic logic [5:0] cyc_up(input int ps);
    int c;
    c = (ps + `CORE_PERIOD_PS - 1) / `CORE_PERIOD_PS;
    if (c < 1) c = 1;
    return 6'(c);
  endfunction

  // Unit interval for the chosen lane rate, floored at the minimum
  function automatic int ui_of(input logic [1:0] sel);
    int u;
    unique case (sel)
      2'h0: u = `UI_150_PS;
      2'h1: u = `UI_300_PS;
      2'h2: u = `UI_450_PS;
      2'h3: u = `UI_600_PS;
    endcase
    if (u < `UI_MIN_PS) u = `UI_MIN_PS;
    return u;
  endfunction

  // Interval counts for the configured rate
  always_comb begin
    int tr;
    tr         = 0;
    ui         = ui_of(CFG.rate);
    tr         = `TRAIL_MIN_UI * ui;
    if (`T_TRAIL_MIN_PS + `TRAIL_ADD_UI * ui > tr) tr = `T_TRAIL_MIN_PS + `TRAIL_ADD_UI * ui;
    t_lpx      = cyc_up(`T_LPX_MIN_PS);
    t_clk_pre  = cyc_up(`T_CLK_PRE_MIN_PS);
    t_clk_prep = cyc_up(`T_CLK_PREP_MIN_PS);
    t_clk_zero = 6'(cyc_up(`T_CLK_PZ_MIN_PS) - t_clk_prep);
    t_hs_prep  = cyc_up(`T_HS_PREP_MIN_PS + `HS_PREP_MIN_UI * ui);
    t_hs_zero  = 6'(cyc_up(`T_HS_PZ_MIN_PS + `HS_PZ_MIN_UI * ui) - t_hs_prep);
    t_trail    = cyc_up(tr);
    t_exit     = cyc_up(`T_EXIT_MIN_PS);
  end

  // Payload beats wait here; a stalled crossing back-pressures the source
  csi_beat_buf #(.WIDTH($bits(beat_t)), .DEPTH(2)) u_buf (
    .clk       (CORE_CLK),
    .srst      (SRST),
    .ce        (CE),
    .in_valid  (DIN_VALID),
    .in_ready  (DIN_READY),
    .in_data   (DIN),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  assign hs_free = (req_r == ack_s2);
  assign load    = hs_free && (d_state_r != D_PAY || head_valid);
  assign pop     = (d_state_r == D_PAY) && hs_free;
  assign pre_ok  = (c_state_r == C_RUN) && (c_cnt_r >= t_clk_pre);

  // Clock lane: LP-11, LP-01, LP-00, HS-0, then toggling until IF_EN drops
  always_comb begin
    logic [5:0] len;
    len         = t_lpx;
    c_state_nxt = c_state_r;
    c_sent_nxt  = c_sent_r | load;
    c_cnt_nxt   = (c_sent_r && c_cnt_r != 6'h3f) ? 6'(c_cnt_r + 1'b1) : c_cnt_r;
    unique case (c_state_r)
      C_OFF, C_LP01: len = t_lpx;
      C_LP00:        len = t_clk_prep;
      C_HS0:         len = t_clk_zero;
      C_RUN:         len = 6'h3f;
    endcase
    if (c_state_r != C_RUN && c_sent_r && c_cnt_r >= 6'(len - 1'b1)) begin
      unique case (c_state_r)
        C_OFF:  c_state_nxt = C_LP01;
        C_LP01: c_state_nxt = C_LP00;
        C_LP00: c_state_nxt = C_HS0;
        C_HS0:  c_state_nxt = C_RUN;
        C_RUN:  c_state_nxt = C_RUN;
      endcase
    end
    if (!IF_EN) c_state_nxt = C_OFF;
    if (c_state_nxt != c_state_r) begin
      c_cnt_nxt  = '0;
      c_sent_nxt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      c_state_r <= C_OFF;
      c_cnt_r   <= '0;
      c_sent_r  <= 1'b0;
    end else if (CE) begin
      c_state_r <= c_state_nxt;
      c_cnt_r   <= c_cnt_nxt;
      c_sent_r  <= c_sent_nxt;
    end
  end

  // Data lanes: one burst walks LP-11 to trail and back
  always_comb begin
    logic [5:0] len;
    logic       go;
    len         = t_lpx;
    go          = 1'b0;
    d_state_nxt = d_state_r;
    d_sent_nxt  = d_sent_r | load;
    d_cnt_nxt   = (d_sent_r && d_cnt_r != 6'h3f) ? 6'(d_cnt_r + 1'b1) : d_cnt_r;
    last_nxt    = (pop && head_valid) ? head.data : last_r;
    unique case (d_state_r)
      D_LP11:  len = t_exit;
      D_LP01:  len = t_lpx;
      D_LP00:  len = t_hs_prep;
      D_HS0:   len = t_hs_zero;
      D_SYNC:  len = 6'h01;
      D_PAY:   len = 6'h01;
      D_TRAIL: len = t_trail;
    endcase
    if (d_sent_r && d_cnt_r >= 6'(len - 1'b1)) go = 1'b1;
    unique case (d_state_r)
      D_LP11:  if (go && pre_ok && head_valid) d_state_nxt = D_LP01;
      D_LP01:  if (go) d_state_nxt = D_LP00;
      D_LP00:  if (go) d_state_nxt = D_HS0;
      D_HS0:   if (go) d_state_nxt = D_SYNC;
      D_SYNC:  if (go) d_state_nxt = D_PAY;
      D_PAY:   if (pop && head_valid && head.last) d_state_nxt = D_TRAIL;
      D_TRAIL: if (go) d_state_nxt = D_LP11;
    endcase
    if (!IF_EN) d_state_nxt = D_LP11;
    if (d_state_nxt != d_state_r) begin
      d_cnt_nxt  = '0;
      d_sent_nxt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      d_state_r <= D_LP11;
      d_cnt_r   <= '0;
      d_sent_r  <= 1'b0;
      last_r    <= '0;
    end else if (CE) begin
      d_state_r <= d_state_nxt;
      d_cnt_r   <= d_cnt_nxt;
      d_sent_r  <= d_sent_nxt;
      last_r    <= last_nxt;
    end
  end

  // Line word per lane from its role, polarity applied per wire
  always_comb begin
    logic       p, n, h;
    logic [7:0] b;
    p        = 1'b1;
    n        = 1'b1;
    h        = 1'b0;
    b        = 8'h00;
    word_nxt = word_r;
    req_nxt  = req_r;
    if (load) begin
      req_nxt = ~req_r;
      for (int i = 0; i < `NUM_LANES; i++) begin
        p = 1'b1;
        n = 1'b1;
        h = 1'b0;
        b = 8'h00;
        if (CFG.clk_role[i]) begin
          unique case (c_state_r)
            C_OFF:  begin p = 1'b1; n = 1'b1; end
            C_LP01: begin p = 1'b0; n = 1'b1; end
            C_LP00: begin p = 1'b0; n = 1'b0; end
            C_HS0:  h = 1'b1;
            C_RUN:  begin h = 1'b1; b = `CLK_BYTE; end
          endcase
        end else begin
          unique case (d_state_r)
            D_LP11:  begin p = 1'b1; n = 1'b1; end
            D_LP01:  begin p = 1'b0; n = 1'b1; end
            D_LP00:  begin p = 1'b0; n = 1'b0; end
            D_HS0:   h = 1'b1;
            D_SYNC:  begin h = 1'b1; b = `SYNC_BYTE; end
            D_PAY:   begin h = 1'b1; b = head.data[8*i +: 8]; end
            D_TRAIL: begin h = 1'b1; b = {8{~last_r[8*i+7]}}; end
          endcase
        end
        word_nxt.lp_p[i]         = p ^ CFG.inv_p[i];
        word_nxt.lp_n[i]         = n ^ CFG.inv_n[i];
        word_nxt.hs_en[i]        = h;
        word_nxt.hs_byte[8*i +: 8] = b ^ {8{CFG.inv_p[i] ^ CFG.inv_n[i]}};
      end
    end
  end

  // Word and request toggle held until the link acknowledges
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      word_r <= `LINE_RESET;
      req_r  <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else if (CE) begin
      word_r <= word_nxt;
      req_r  <= req_nxt;
      ack_s1 <= ack_r;
      ack_s2 <= ack_s1;
    end
  end

  assign CLK_LANE_HS = (c_state_r == C_RUN);
  assign BURST_BUSY  = (d_state_r != D_LP11);

  // Link domain: take each new word once the request toggle has settled
  always_comb begin
    out_nxt = out_r;
    ack_nxt = ack_r;
    if (rq_s2 != ack_r) begin
      out_nxt = word_r;
      ack_nxt = rq_s2;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    lrst_s1 <= SRST;
    lrst_s2 <= lrst_s1;
    if (lrst_s2) begin
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      ack_r <= 1'b0;
      out_r <= `LINE_RESET;
    end else begin
      rq_s1 <= req_r;
      rq_s2 <= rq_s1;
      ack_r <= ack_nxt;
      out_r <= out_nxt;
    end
  end

  assign LANE_OUT = out_r;

  // Checks on the core-side sequencing
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  clk_stays_hs_a: assert property (CE && IF_EN && c_state_r == C_RUN |=>
    c_state_r == C_RUN)
    else $error("clock lane left HS while enabled");
  clk_pre_a: assert property (d_state_r == D_LP11 && d_state_nxt == D_LP01 && CE |->
    c_state_r == C_RUN && (int'(c_cnt_r) + 1) * `CORE_PERIOD_PS >= `T_CLK_PRE_MIN_PS)
    else $error("data entry before clock pre time");
  clk_prep_a: assert property (CE && IF_EN && c_state_r == C_LP00 &&
    c_state_nxt == C_HS0 |->
    (int'(c_cnt_r) + 1) * `CORE_PERIOD_PS inside {[`T_CLK_PREP_MIN_PS:`T_CLK_PREP_MAX_PS]})
    else $error("clock prepare out of range");
  clk_zero_a: assert property (CE && c_state_r == C_HS0 && c_state_nxt == C_RUN |->
    (int'(t_clk_prep) + int'(c_cnt_r) + 1) * `CORE_PERIOD_PS >= `T_CLK_PZ_MIN_PS)
    else $error("clock prepare plus zero too short");
  hs_prep_a: assert property (CE && IF_EN && d_state_r == D_LP00 &&
    d_state_nxt == D_HS0 |->
    (int'(d_cnt_r) + 1) * `CORE_PERIOD_PS >= `T_HS_PREP_MIN_PS + `HS_PREP_MIN_UI * ui &&
    (int'(d_cnt_r) + 1) * `CORE_PERIOD_PS <= `T_HS_PREP_MAX_PS + `HS_PREP_MAX_UI * ui)
    else $error("data prepare out of range");
  hs_zero_a: assert property (CE && d_state_r == D_HS0 && d_state_nxt == D_SYNC |->
    (int'(t_hs_prep) + int'(d_cnt_r) + 1) * `CORE_PERIOD_PS >=
    `T_HS_PZ_MIN_PS + `HS_PZ_MIN_UI * ui)
    else $error("data prepare plus zero too short");
  trail_len_a: assert property (CE && IF_EN && d_state_r == D_TRAIL &&
    d_state_nxt == D_LP11 |->
    (int'(d_cnt_r) + 1) * `CORE_PERIOD_PS >= `TRAIL_MIN_UI * ui &&
    (int'(d_cnt_r) + 1) * `CORE_PERIOD_PS >= `T_TRAIL_MIN_PS + `TRAIL_ADD_UI * ui)
    else $error("trail too short");
  trail_eot_a: assert property (CE && d_state_r == D_TRAIL && d_state_nxt == D_LP11 |->
    (int'(t_trail)) * `CORE_PERIOD_PS <= `T_EOT_MAX_PS + `EOT_MAX_UI * ui)
    else $error("trail exceeds end of burst limit");
  exit_len_a: assert property (CE && d_state_r == D_LP11 && d_state_nxt == D_LP01 |->
    (int'(d_cnt_r) + 1) * `CORE_PERIOD_PS >= `T_EXIT_MIN_PS)
    else $error("LP-11 exit time too short");
  lp_len_a: assert property (CE && IF_EN && d_state_r == D_LP01 &&
    d_state_nxt != D_LP01 |->
    (int'(d_cnt_r) + 1) * `CORE_PERIOD_PS >= `T_LPX_MIN_PS)
    else $error("LP state too short");
  ui_floor_a: assert property (ui >= `UI_MIN_PS)
    else $error("unit interval below minimum");
  burst_order_a: assert property (CE && IF_EN && d_state_r == D_SYNC &&
    d_state_nxt != D_SYNC |->
    d_state_nxt == D_PAY ##1 (d_state_r == D_PAY)[*1])
    else $error("burst left sync out of order");

  clk_run_c:   cover property ($rose(c_state_r == C_RUN));
  burst_done_c: cover property (d_state_r == D_TRAIL ##1 d_state_r == D_LP11);
  buf_full_c:  cover property (DIN_VALID && !DIN_READY);
endmodule // csi_dphy_lane_sequencer

//--- dv/csi_rx_model.sv
// Receiver model: decodes the data lanes (line state from the first) and the clock lane at the pins
`timescale 1ns/100ps
`include "csi_lane_map.svh"
module csi_rx_model (
  input  wire logic                    link_clk,
  input  wire logic                    en,
  input  wire csi_lane_pkg::lane_cfg_t cfg,
  input  wire csi_lane_pkg::line_t     line,
  output logic                         ev_valid,
  output logic [2:0]                   ev_kind,
  output longint                       ev_ps,
  output logic [31:0]                  ev_word,
  output longint                       lead_ps,
  output longint                       prep_ps,
  output longint                       pz_ps,
  output int                           drops
);
  import csi_lane_pkg::*;
  logic [1:0]  d, c, cls, pcls, pd, pc;
  logic [7:0]  cb;
  logic [31:0] w;
  logic [34:0] sig, psig;
  logic        armed, run;
  longint      now, t0, tl, th, rt;
  int          hs_n;
  int          drop_n = 0;

  // Lane roles, wire polarity undone, line state signature
  always_comb begin
    d = 2'd0;
    c = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (cfg.clk_role[i])
        c = 2'(i);
      else
        d = 2'(i);
      w[8*i +: 8] = cfg.clk_role[i] ? 8'h00 :
                    line.hs_byte[8*i +: 8] ^ {8{cfg.inv_p[i] ^ cfg.inv_n[i]}};
    end
    cb = line.hs_byte[8*c +: 8] ^ {8{cfg.inv_p[c] ^ cfg.inv_n[c]}};
    pc = {line.lp_p[c] ^ cfg.inv_p[c], line.lp_n[c] ^ cfg.inv_n[c]};
    pd = {line.lp_p[d] ^ cfg.inv_p[d], line.lp_n[d] ^ cfg.inv_n[d]};
    cls = !line.hs_en[c] ? (pc == 2'b00 ? 2'd1 : 2'd0) :
          cb == 8'h00 ? 2'd2 : cb == `CLK_BYTE ? 2'd3 : 2'd0;
    sig = {line.hs_en[d], line.hs_en[d] ? 2'b00 : pd, line.hs_en[d] ? w : 32'h0};
  end

  assign drops = drop_n;

  // Segment timing and reporting, clock lane start-up times
  always @(posedge link_clk) begin
    ev_valid <= 1'b0;
    now = longint'($realtime * 1000.0);
    if (!en) begin
      armed <= 1'b0;
      run <= 1'b0;
    end else if (!armed) begin
      armed <= 1'b1;
      psig <= sig;
      pcls <= cls;
      t0 <= now;
      hs_n <= 0;
    end else begin
      if (sig != psig) begin
        ev_valid <= 1'b1;
        ev_ps <= now - t0;
        ev_word <= psig[31:0];
        lead_ps <= run ? now - rt : 0;
        if (!psig[34])
          ev_kind <= psig[33:32] == 2'b11 ? 3'd0 : psig[33:32] == 2'b01 ? 3'd1 :
                     psig[33:32] == 2'b00 ? 3'd2 : 3'd7;
        else
          ev_kind <= !sig[34] ? 3'd6 : hs_n == 0 ? 3'd3 : hs_n == 1 ? 3'd4 : 3'd5;
        hs_n <= (psig[34] && sig[34]) ? hs_n + 1 : 0;
        t0 <= now;
        psig <= sig;
      end
      if (cls != pcls) begin
        pcls <= cls;
        if (cls == 2'd1)
          tl <= now;
        if (cls == 2'd2)
          th <= now;
        if (cls == 2'd3) begin
          prep_ps <= th - tl;
          pz_ps <= now - tl;
          rt <= now;
          run <= 1'b1;
        end
      end
      if (run && cls != 2'd3)
        drop_n <= drop_n + 1;
    end
  end
endmodule // csi_rx_model

//--- dv/csi_dphy_lane_sequencer_test.sv
// Self-checking bench for the lane sequencer with a receiver model
`timescale 1ns/100ps
`include "csi_lane_map.svh"
module csi_dphy_lane_sequencer_test;
  import csi_lane_pkg::*;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        srst, ce, if_en, en_m, din_valid, din_ready, clk_hs, busy, ev_valid, acc;
  lane_cfg_t   cfg;
  beat_t       din;
  line_t       lane;
  logic [2:0]  ev_kind;
  longint      ev_ps, lead_ps, prep_ps, pz_ps, ui, prep;
  logic [31:0] ev_word, mask, last_w, prev_w, q[$];
  int          drops, seed, n, k, exp_k, last_k, full_seen;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  // Clocks of the two domains
  initial forever #12.5 core_clk = ~core_clk;
  initial #7 forever #32 link_clk = ~link_clk;

  csi_dphy_lane_sequencer i_dut (
    .CORE_CLK(core_clk), .SRST(srst), .CE(ce), .IF_EN(if_en), .CFG(cfg),
    .DIN_VALID(din_valid), .DIN_READY(din_ready), .DIN(din), .LINK_CLK(link_clk),
    .LANE_OUT(lane), .CLK_LANE_HS(clk_hs), .BURST_BUSY(busy));

  csi_rx_model i_rx (
    .link_clk(link_clk), .en(en_m), .cfg(cfg), .line(lane), .ev_valid(ev_valid),
    .ev_kind(ev_kind), .ev_ps(ev_ps), .ev_word(ev_word), .lead_ps(lead_ps),
    .prep_ps(prep_ps), .pz_ps(pz_ps), .drops(drops));

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_t(input longint got, input longint lo);
    cmp_count++;
    if (got < lo) begin
      bad_count++;
      $display("Error at %0t: interval %0d ps below %0d ps", $time, got, lo);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] trail(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      trail[8*i +: 8] = {8{~v[8*i+7]}};
  endfunction

  // Offer one beat, CE random, until taken
  task automatic send(input logic last);
    din_valid = 1'b1;
    din.last = last;
    din.data = $random(seed);
    if ((din.data & mask) == prev_w)
      din.data = ~din.data;
    forever begin
      ce = ($random(seed) & 3) != 0;
      if (din_ready !== 1'b1)
        full_seen = 1;
      acc = din_ready === 1'b1 && ce;
      @(negedge core_clk);
      if (acc)
        break;
    end
    ce = 1'b1;
    q.push_back(din.data & mask);
    prev_w = din.data & mask;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end

  // Checks each line state segment the receiver reports
  always @(negedge link_clk) begin
    if (ev_valid === 1'b1) begin
      exp_k = last_k == 5 ? (ev_kind == 3'd6 ? 6 : 5) : (last_k == 6 ? 0 : last_k + 1);
      chk_w(32'(ev_kind), 32'(exp_k));
      last_k = int'(ev_kind);
      case (ev_kind)
        3'd0: begin
          chk_t(ev_ps, 100000);
          chk_t(lead_ps, 8000);
          chk_t(prep_ps, 38000);
          chk_t(pz_ps, 300000);
        end
        3'd1: chk_t(ev_ps, 50000);
        3'd2: begin
          prep = ev_ps;
          chk_t(ev_ps, 40000 + 4 * ui);
        end
        3'd3: begin
          chk_w(ev_word, 32'h0);
          chk_t(prep + ev_ps, 145000 + 10 * ui);
        end
        3'd4: chk_w(ev_word, {4{`SYNC_BYTE}} & mask);
        3'd5: begin
          last_w = ev_word;
          chk_w(ev_word, q.size() > 0 ? q.pop_front() : 32'hx);
        end
        default: begin
          chk_w(ev_word, trail(last_w) & mask);
          chk_t(ev_ps, (8 * ui > 60000 + 4 * ui) ? 8 * ui : 60000 + 4 * ui);
        end
      endcase
    end
  end

  // Main sequence: eight configurations, two bursts each
  initial begin
    seed = 69;
    srst = 1'b1;
    ce = 1'b1;
    if_en = 1'b0;
    en_m = 1'b0;
    cfg = '0;
    din_valid = 1'b0;
    din = '0;
    last_k = 6;
    full_seen = 0;
    last_w = 32'h0;
    prev_w = 32'h0;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if_en = 1'b0;
      en_m = 1'b0;
      repeat (10) @(negedge core_clk);
      cfg.clk_role = 4'h1 << ($random(seed) & 3);
      cfg.inv_p = 4'($random(seed));
      cfg.inv_n = 4'($random(seed));
      cfg.rate = 2'(r);
      ui = r % 4 == 0 ? `UI_150_PS : r % 4 == 1 ? `UI_300_PS :
           r % 4 == 2 ? `UI_450_PS : `UI_600_PS;
      for (int i = 0; i < 4; i++)
        mask[8*i +: 8] = cfg.clk_role[i] ? 8'h00 : 8'hff;
      repeat (40) @(negedge core_clk);
      en_m = 1'b1;
      if_en = 1'b1;
      for (k = 0; k < 2000 && clk_hs !== 1'b1; k++)
        @(negedge core_clk);
      chk_w(32'(clk_hs), 32'h1);
      repeat (2) begin
        n = 1 + ($random(seed) & 3);
        for (int b = 1; b <= n; b++) begin
          send(b == n);
          if ($random(seed) & 1) begin
            din_valid = 1'b0;
            repeat (8) @(negedge core_clk);
          end
        end
        din_valid = 1'b0;
        for (k = 0; k < 3000 && (q.size() > 0 || busy !== 1'b0); k++)
          @(negedge core_clk);
        chk_w(32'(busy), 32'h0);
        // Let the closing LP-11 word cross to the pins before moving on
        repeat (40) @(negedge core_clk);
      end
    end
    repeat (50) @(negedge core_clk);
    chk_w(32'(drops), 32'h0);
    chk_w(32'(q.size()), 32'h0);
    chk_w(32'(full_seen), 32'h1);
    summarize();
  end
endmodule // csi_dphy_lane_sequencer_test
